/* File: rtl/aetc_defines.svh */
// register offsets, field positions, reset values and timing counts for the timing block
`ifndef AETC_DEFINES_SVH
`define AETC_DEFINES_SVH

`define AETC_CLK_MHZ 125
`define AETC_STROBE_MIN_NS 500
// least time rounds up to whole cycles
`define AETC_STROBE_CYC ((`AETC_STROBE_MIN_NS * `AETC_CLK_MHZ + 999) / 1000)
`define AETC_SCAN_PULSE_CYC 4

`define AETC_OFF_CTRL 12'h000
`define AETC_OFF_STROBE 12'h004
`define AETC_OFF_CHAN 12'h008
`define AETC_OFF_STATUS 12'h00c
`define AETC_OFF_IRQ_STAT 12'h010
`define AETC_OFF_IRQ_MASK 12'h014
`define AETC_OFF_DAC0 12'h018
`define AETC_OFF_DAC1 12'h01c
`define AETC_OFF_CONVCNT 12'h020

// control fields
`define AETC_CTRL_ARM 0
`define AETC_CTRL_PRETRIG 1
`define AETC_CTRL_TMR_SEL 2
`define AETC_CTRL_POSTED 3
`define AETC_CTRL_TMR_IRQ_EN 4
`define AETC_CTRL_SENSE_GND 5
`define AETC_CTRL_MODE_LO 6
`define AETC_CTRL_SCAN 8
`define AETC_CTRL_RESET 32'h0000_0000

// interrupt status bits
`define AETC_IRQ_TIMED 0
`define AETC_IRQ_CONV 1
`define AETC_IRQ_TRIG 2
`define AETC_IRQ_W 3

`define AETC_DAC_W 12
`define AETC_CHAN_W 6
`define AETC_DIFFERENTIAL_INPUT_CHANS 32
`define AETC_SE_CHANS 64

`endif

/* File: rtl/aetc_pkg.sv */
// types for the external timing block
package aetc_pkg;
	typedef enum logic [1:0] {
		AETC_SE_GROUND = 2'b00,
		AETC_SE_FLOAT = 2'b01,
		AETC_DIFFERENTIAL_INPUT = 2'b10
	} aetc_mode_t;

	typedef enum logic [1:0] {
		AETC_IDLE = 2'b00,
		AETC_PRE = 2'b01,
		AETC_POST = 2'b10
	} aetc_acq_t;

	// external inputs, triggers active low, conversion gate permits while high
	typedef struct packed {
		logic acq_trigger_in_n;
		logic conv_gate_in_n;
		logic conv_start_in_n;
		logic dac_update_trigger_in_n;
	} aetc_ext_t;

	// counter lines passed through, registered once
	typedef struct packed {
		logic ctr_a_source;
		logic ctr_a_gate;
		logic ctr_a_output;
		logic ctr_b_gate;
		logic ctr_b_output;
		logic ctr_e_source;
		logic ctr_e_gate;
		logic ctr_e_output;
		logic freq_out;
	} aetc_ctr_t;
endpackage

/* File: rtl/aetc_top.sv */
// external timing, trigger and strobe control with apb registers
`include "aetc_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module aetc_top
	import aetc_pkg::*;
(
	input wire logic clock, // 125 MHz board clock
	input wire logic resetn, // synchronous, active low
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb direction
	input wire logic [11:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error, unmapped address
	input wire aetc_ext_t ext_in, // external trigger inputs
	input wire aetc_ctr_t ctr_in, // counter chip lines
	output aetc_ctr_t ctr_out, // counter lines to connector
	output logic scan_pulse_out, // scan clock
	output logic strobe_out_n, // external strobe, active low
	output logic adc_convert, // one-cycle convert to the converter
	output logic [5:0] chan_sel, // analog channel select
	output logic sense_to_ground, // drive sense line from ground
	output logic [11:0] dac0_out, // dac 0 live value
	output logic [11:0] dac1_out, // dac 1 live value
	output logic irq // level interrupt
);
	logic [31:0] ctrl_q;
	logic [5:0] chan_q;
	logic [2:0] irq_stat_q;
	logic [2:0] irq_mask_q;
	logic [11:0] dac0_wr_q;
	logic [11:0] dac1_wr_q;
	logic [15:0] conv_cnt_q;
	aetc_acq_t acq_q;
	logic [3:0] sync1_q;
	logic [3:0] sync2_q;
	logic [3:0] prev_q;
	logic [3:0] fall;
	logic [7:0] strobe_cnt_q;
	logic [2:0] scan_cnt_q;
	logic apb_wr;
	logic apb_rd;
	logic strobe_wr;
	logic conv_ok;
	logic timed_ev;
	logic dac_load;
	aetc_mode_t mode;
	logic trig_fall;
	logic conv_fall;
	logic tmr_fall;
	logic gate_open;
	logic acq_active;
	logic conv_take;
	logic irq_clr_wr;
	logic [2:0] irq_set;
	logic [2:0] irq_clr;
	logic [2:0] irq_pend;
	logic [31:0] rd_word;
	logic addr_err;

	assign apb_wr = psel && penable && pwrite;
	assign apb_rd = psel && !penable && !pwrite;
	assign strobe_wr = apb_wr && (paddr == `AETC_OFF_STROBE);
	assign mode = aetc_mode_t'(ctrl_q[`AETC_CTRL_MODE_LO +: 2]);

	// two-flop synchroniser and falling edge detect per input
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_sync
			always_ff @(posedge clock)
			begin
				if (!resetn)
				begin
					sync1_q[gi] <= 1'b1;
					sync2_q[gi] <= 1'b1;
					prev_q[gi] <= 1'b1;
				end
				else
				begin
					sync1_q[gi] <= ext_in[gi];
					sync2_q[gi] <= sync1_q[gi];
					prev_q[gi] <= sync2_q[gi];
				end
			end
			assign fall[gi] = prev_q[gi] && !sync2_q[gi];
		end
	endgenerate
	// bit order follows the struct: 3 trigger, 2 gate, 1 convert, 0 timer
	// named aliases so only the status read below still depends on that order
	assign trig_fall = fall[3];
	assign conv_fall = fall[1];
	assign tmr_fall = fall[0];
	assign gate_open = sync2_q[2];

	// gate high permits, only while a sequence runs
	assign acq_active = (acq_q != AETC_IDLE);
	assign conv_ok = acq_active && gate_open;
	// one accepted edge feeds the convert pulse, the count and the scan clock
	assign conv_take = conv_fall && conv_ok;
	assign timed_ev = tmr_fall && ctrl_q[`AETC_CTRL_TMR_SEL];
	assign dac_load = timed_ev && ctrl_q[`AETC_CTRL_POSTED];

	// acquisition sequencer; arm bit cleared by software ends it
	always_ff @(posedge clock)
	begin
		if (!resetn)
			acq_q <= AETC_IDLE;
		else if (!ctrl_q[`AETC_CTRL_ARM])
			acq_q <= AETC_IDLE;
		else
		begin
			case (acq_q)
				AETC_IDLE:
					if (trig_fall)
						acq_q <= ctrl_q[`AETC_CTRL_PRETRIG] ? AETC_PRE : AETC_POST;
				// a third trigger edge is ignored; only disarming ends the run
				AETC_PRE:
					if (trig_fall)
						acq_q <= AETC_POST;
				AETC_POST:
					acq_q <= AETC_POST;
				default:
					acq_q <= AETC_IDLE;
			endcase
		end
	end

	// one convert pulse per accepted edge
	// the count wraps at 16 bits; software treats it as a running tally
	always_ff @(posedge clock)
	begin
		if (!resetn)
		begin
			adc_convert <= 1'b0;
			conv_cnt_q <= 16'h0000;
		end
		else
		begin
			adc_convert <= conv_take;
			if (conv_take)
				conv_cnt_q <= conv_cnt_q + 16'h0001;
		end
	end

	// scan pulse: low while converting, rising edge frees the input
	// limitation: a convert within four cycles restarts the count and drops a pulse
	always_ff @(posedge clock)
	begin
		if (!resetn)
		begin
			scan_cnt_q <= 3'h0;
			scan_pulse_out <= 1'b0;
		end
		else if (conv_take && ctrl_q[`AETC_CTRL_SCAN])
		begin
			scan_cnt_q <= 3'(`AETC_SCAN_PULSE_CYC);
			scan_pulse_out <= 1'b0;
		end
		else if (scan_cnt_q != 3'h0)
		begin
			scan_cnt_q <= scan_cnt_q - 3'h1;
			scan_pulse_out <= (scan_cnt_q == 3'h1);
		end
		else
			scan_pulse_out <= 1'b0;
	end

	// strobe low for the minimum time; a new write restarts it
	// a write while low stretches the pulse rather than leaving a gap
	always_ff @(posedge clock)
	begin
		if (!resetn)
		begin
			strobe_cnt_q <= 8'h00;
			strobe_out_n <= 1'b1;
		end
		else if (strobe_wr)
		begin
			strobe_cnt_q <= 8'(`AETC_STROBE_CYC);
			strobe_out_n <= 1'b0;
		end
		else if (strobe_cnt_q != 8'h00)
		begin
			strobe_cnt_q <= strobe_cnt_q - 8'h01;
			strobe_out_n <= (strobe_cnt_q == 8'h01);
		end
		else
			strobe_out_n <= 1'b1;
	end

	// software registers
	// read-only and unmapped offsets fall to default and change nothing
	always_ff @(posedge clock)
	begin
		if (!resetn)
		begin
			ctrl_q <= `AETC_CTRL_RESET;
			chan_q <= 6'h00;
			irq_mask_q <= 3'h0;
			dac0_wr_q <= 12'h000;
			dac1_wr_q <= 12'h000;
		end
		else if (apb_wr)
		begin
			case (paddr)
				`AETC_OFF_CTRL: ctrl_q <= {23'h000000, pwdata[8:0]};
				`AETC_OFF_CHAN: chan_q <= pwdata[5:0];
				`AETC_OFF_IRQ_MASK: irq_mask_q <= pwdata[2:0];
				`AETC_OFF_DAC0: dac0_wr_q <= pwdata[11:0];
				`AETC_OFF_DAC1: dac1_wr_q <= pwdata[11:0];
				default: ctrl_q <= ctrl_q;
			endcase
		end
	end

	// dacs: immediate unless posted, posted waits for a timer edge with timer select set
	always_ff @(posedge clock)
	begin
		if (!resetn)
		begin
			dac0_out <= 12'h000;
			dac1_out <= 12'h000;
		end
		else if (dac_load || !ctrl_q[`AETC_CTRL_POSTED])
		begin
			dac0_out <= dac0_wr_q;
			dac1_out <= dac1_wr_q;
		end
	end

	// differential folds to 32 channels, single-ended uses all 64
	always_ff @(posedge clock)
	begin
		if (!resetn)
		begin
			chan_sel <= 6'h00;
			sense_to_ground <= 1'b0;
		end
		else
		begin
			chan_sel <= (mode == AETC_DIFFERENTIAL_INPUT) ? {1'b0, chan_q[4:0]} : chan_q;
			// floating single-ended needs sense as reference, so never ground it there
			sense_to_ground <= ctrl_q[`AETC_CTRL_SENSE_GND] && (mode != AETC_SE_FLOAT);
		end
	end

	// event bits in status order: 2 trigger, 1 conversion, 0 timed
	assign irq_set[`AETC_IRQ_TRIG] = trig_fall && ctrl_q[`AETC_CTRL_ARM];
	assign irq_set[`AETC_IRQ_CONV] = conv_take;
	assign irq_set[`AETC_IRQ_TIMED] = timed_ev && ctrl_q[`AETC_CTRL_TMR_IRQ_EN];
	// write-one-to-clear acts only on the access edge of a status write
	assign irq_clr_wr = apb_wr && (paddr == `AETC_OFF_IRQ_STAT);
	assign irq_clr = irq_clr_wr ? pwdata[2:0] : 3'h0;

	// sticky status, set wins over write-one-to-clear
	always_ff @(posedge clock)
	begin
		if (!resetn)
			irq_stat_q <= 3'h0;
		else
		begin
			irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set; // set applied last, so it wins
		end
	end

	// interrupt level registered so the pin comes straight from a flop
	assign irq_pend = irq_stat_q & irq_mask_q;
	always_ff @(posedge clock)
	begin
		if (!resetn)
			irq <= 1'b0;
		else
			irq <= |irq_pend;
	end

	// counter lines registered once; one cycle of delay, levels unchanged
	always_ff @(posedge clock)
	begin
		if (!resetn)
			ctr_out <= '0;
		else
			ctr_out <= ctr_in;
	end

	// read mux; an unmapped offset answers zero and flags an error
	always_comb
	begin
		rd_word = 32'h0000_0000;
		addr_err = 1'b0;
		case (paddr)
			`AETC_OFF_CTRL: rd_word = ctrl_q;
			`AETC_OFF_STROBE: rd_word = {31'h0, strobe_out_n};
			`AETC_OFF_CHAN: rd_word = {26'h0, chan_q};
			// status: synchronised pin levels, sequencer state, busy flag
			`AETC_OFF_STATUS: rd_word = {25'h0, sync2_q, acq_q, acq_active};
			`AETC_OFF_IRQ_STAT: rd_word = {29'h0, irq_stat_q};
			`AETC_OFF_IRQ_MASK: rd_word = {29'h0, irq_mask_q};
			`AETC_OFF_DAC0: rd_word = {20'h0, dac0_out};
			`AETC_OFF_DAC1: rd_word = {20'h0, dac1_out};
			`AETC_OFF_CONVCNT: rd_word = {16'h0, conv_cnt_q};
			default: addr_err = 1'b1;
		endcase
	end

	// apb: answer prepared in setup, shown in the first access cycle
	// write answers carry zero data so a stale word never reaches the bus
	always_ff @(posedge clock)
	begin
		if (!resetn)
		begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && addr_err;
			if (psel && !penable)
				prdata <= apb_rd ? rd_word : 32'h0000_0000;
		end
	end
endmodule

`default_nettype wire

/* File: verification/aetc_chk.sv */
// port assertions for the external timing block
`timescale 1ns/100ps
`default_nettype none
module aetc_chk
	import aetc_pkg::*;
(
	input wire logic clock, // clock
	input wire logic resetn, // reset
	input wire logic psel, // apb
	input wire logic penable, // apb
	input wire logic pwrite, // apb
	input wire logic [11:0] paddr, // apb
	input wire logic pready, // apb
	input wire aetc_ext_t ext_in, // pins
	input wire aetc_ctr_t ctr_in, // counter in
	input wire aetc_ctr_t ctr_out, // counter out
	input wire logic scan_pulse_out, // scan
	input wire logic strobe_out_n, // strobe
	input wire logic adc_convert // convert
);
	logic [7:0] low_q;
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	// strobe low time, saturating so a stuck strobe cannot wrap
	always_ff @(posedge clock)
	begin
		if (!resetn || strobe_out_n)
			low_q <= 8'h00;
		else if (low_q != 8'hff)
			low_q <= low_q + 8'h01;
	end
	a_strobe_start: assert property (psel && penable && pwrite && paddr == 12'h004
		|-> ##[1:2] !strobe_out_n) else $error("strobe late");
	a_strobe_width: assert property ($rose(strobe_out_n) |-> low_q >= 8'h3f)
		else $error("strobe short");
	a_scan_cause: assert property (scan_pulse_out |-> $past(adc_convert, 4))
		else $error("stray scan pulse");
	a_conv_single: assert property (adc_convert |=> !adc_convert)
		else $error("double convert");
	a_conv_gate: assert property (adc_convert |-> $past(ext_in.conv_gate_in_n, 3))
		else $error("convert while gated");
	a_conv_cause: assert property (adc_convert |-> !$past(ext_in.conv_start_in_n, 3))
		else $error("convert without edge");
	a_apb_ready: assert property (psel && penable && !$past(penable) |-> pready)
		else $error("no ready");
	a_ctr_pass: assert property ($past(resetn) |-> ctr_out == $past(ctr_in))
		else $error("counter line altered");
endmodule
`default_nettype wire

/* File: verification/aetc_ext_model.sv */
// external instruments on the connector side
`timescale 1ns/100ps
`default_nettype none
module aetc_ext_model
	import aetc_pkg::*;
(
	input wire logic clock, // board clock
	output var aetc_ext_t ext_in, // trigger pins
	output var aetc_ctr_t ctr_in // counter lines
);
	// pins idle high
	initial
		ext_in = 4'hf;
	// lines change every cycle so a stale copy shows
	initial
	begin
		ctr_in = '0;
		forever
			@(posedge clock) ctr_in <= aetc_ctr_t'(ctr_in + 9'h001);
	end
	// one falling edge, long enough for the synchronisers
	task fall(input int b);
		@(posedge clock);
		ext_in[b] <= 1'b0;
		repeat (6) @(posedge clock);
		ext_in[b] <= 1'b1;
		repeat (6) @(posedge clock);
	endtask
	// gate level
	task gate(input logic v);
		@(posedge clock);
		ext_in.conv_gate_in_n <= v;
		repeat (6) @(posedge clock);
	endtask
endmodule
`default_nettype wire

/* File: verification/tb.sv */
// testbench for the external timing block
`timescale 1ns/100ps
`default_nettype none
module tb;
	import aetc_pkg::*;
	localparam int TRG = 3;
	localparam int CNV = 1;
	localparam int TMR = 0;
	logic clock = 1'b0;
	logic resetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, scan_pulse_out, strobe_out_n, adc_convert, sense_to_ground, irq;
	logic [5:0] chan_sel;
	logic [11:0] dac0_out, dac1_out;
	logic [32:0] r;
	aetc_ext_t ext_in;
	aetc_ctr_t ctr_in, ctr_out;
	int miscompares = 0;
	int n_checks = 0;
	int nconv = 0;
	int nscan = 0;
	int n;
	aetc_top aetc_top_inst(.clock, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .ext_in, .ctr_in, .ctr_out, .scan_pulse_out,
		.strobe_out_n, .adc_convert, .chan_sel, .sense_to_ground, .dac0_out, .dac1_out, .irq);
	aetc_ext_model mdl(.clock, .ext_in, .ctr_in);
	always #4 clock = ~clock;
	// converter starts and scan pulses seen
	always @(posedge clock)
	begin
		nconv <= nconv + int'(adc_convert === 1'b1);
		nscan <= nscan + int'(scan_pulse_out === 1'b1);
	end
	task summarize;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task chk(input logic [32:0] g, input logic [32:0] e);
		n_checks++;
		if (g !== e)
		begin
			$display("Error at %0t: got %h expected %h", $time, g, e);
			miscompares++;
		end
	endtask
	// one apb transfer, result is {error, read data}
	task xf(input logic w, input logic [11:0] a, input logic [31:0] d);
		int i;
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		i = 0;
		do
		begin
			@(posedge clock);
			i++;
		end
		while (pready !== 1'b1 && i < 20);
		r = {pslverr, prdata};
		if (i >= 20)
		begin
			miscompares++;
			summarize();
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		xf(1'b1, a, d);
	endtask
	task rd(input logic [11:0] a, input logic [32:0] e);
		xf(1'b0, a, 32'h0);
		chk(r, e);
	endtask
	initial
	begin
		repeat (10) @(posedge clock);
		resetn <= 1'b1;
		rd(12'hffc, 33'h1_0000_0000);
		// strobe low time, and it must come back high
		wr(12'h004, 32'h1);
		n = 0;
		repeat (80)
		begin
			@(posedge clock);
			n += int'(strobe_out_n === 1'b0);
		end
		chk(33'(n), 33'h3f);
		// armed but not triggered, then triggered, gated, disarmed
		wr(12'h000, 32'h101);
		mdl.fall(CNV);
		chk(33'(nconv), 33'h0);
		mdl.fall(TRG);
		mdl.fall(CNV);
		chk(33'(nconv), 33'h1);
		chk(33'(nscan), 33'h1);
		mdl.gate(1'b0);
		mdl.fall(CNV);
		chk(33'(nconv), 33'h1);
		mdl.gate(1'b1);
		mdl.fall(CNV);
		chk(33'(nconv), 33'h2);
		wr(12'h000, 32'h0);
		mdl.fall(CNV);
		chk(33'(nconv), 33'h2);
		// pretrigger: two trigger edges
		wr(12'h000, 32'h103);
		mdl.fall(TRG);
		mdl.fall(CNV);
		mdl.fall(TRG);
		mdl.fall(CNV);
		chk(33'(nconv), 33'h4);
		// posted dac load and timed interrupt
		wr(12'h010, 32'h7);
		wr(12'h014, 32'h1);
		wr(12'h000, 32'h1c);
		wr(12'h018, 32'h123);
		wr(12'h01c, 32'h456);
		chk(33'(dac0_out), 33'h0);
		mdl.fall(TMR);
		chk(33'(dac0_out), 33'h123);
		chk(33'(dac1_out), 33'h456);
		rd(12'h010, 33'h1);
		chk(33'(irq), 33'h1);
		wr(12'h010, 32'h1);
		wr(12'h014, 32'h0);
		mdl.fall(TMR);
		chk(33'(irq), 33'h0);
		wr(12'h014, 32'h1);
		repeat (2) @(posedge clock);
		chk(33'(irq), 33'h1);
		// sense grounding, channel range per mode
		wr(12'h000, 32'ha0);
		wr(12'h008, 32'h3f);
		repeat (2) @(posedge clock);
		chk(33'(sense_to_ground), 33'h1);
		chk(33'(chan_sel), 33'h1f);
		wr(12'h000, 32'h0);
		wr(12'h008, 32'h3f);
		repeat (2) @(posedge clock);
		chk(33'(chan_sel), 33'h3f);
		summarize();
	end
endmodule
bind aetc_top aetc_chk aetc_chk_inst(.clock, .resetn, .psel, .penable, .pwrite, .paddr,
	.pready, .ext_in, .ctr_in, .ctr_out, .scan_pulse_out, .strobe_out_n, .adc_convert);
`default_nettype wire
